/* File: pkg/dss_pkg.sv */
// package: object indices, state codes, decode helpers for drive state
// ********************************************************************
// Function
// - read-only state word, bits 0-7, 9 and 10
// - bit 12 meaning follows active mode
// - bit 13 mode error, 14-15 unused
// - low bits encode idle and ready states
// - operation enabled reads x01x 0111
// - quick stop active reads x00x 0111
// - fault reaction 1111, settled fault 1000
// - quick stop option code 0 coasts
// - code 1 fast ramp then disabled
// - code 2 slow ramp then disabled
// - code 3 fast ramp, stay quick stop
// - code 4 slow ramp, stay quick stop
// - fault reaction code 0 freewheels
// - fault code 1 fast ramp then fault
// - fault code 2 slow ramp then fault
// - 32-bit slow decel time, ms, reset 0
// - 32-bit fast stop time, ms, reset 0
// - force-output-enable entry, rw, reset 0
// - output-enable entry, read-only entry count
// - control word 2 stops, then disabled for codes 0-2
// - rising control bit 7 resets fault
// ********************************************************************
package dss_pkg;

  // object indices and subindices
  localparam logic [15:0] IDX_CTRL = 16'h6040;
  localparam logic [15:0] IDX_STAT = 16'h6041;
  localparam logic [15:0] IDX_SLOW = 16'h6050;
  localparam logic [15:0] IDX_FAST = 16'h6051;
  localparam logic [15:0] IDX_QSO  = 16'h605a;
  localparam logic [15:0] IDX_FRO  = 16'h605e;
  localparam logic [15:0] IDX_DOUT = 16'h60fe;
  localparam logic [7:0]  SUB_0    = 8'h00;
  localparam logic [7:0]  SUB_1    = 8'h01;
  localparam logic [7:0]  SUB_2    = 8'h02;
  localparam logic [31:0] DOUT_SUBS = 32'h0000_0002;

  // option codes
  localparam logic [15:0] OPT_COAST    = 16'h0000;
  localparam logic [15:0] QS_FAST_DIS  = 16'h0001;
  localparam logic [15:0] QS_FAST_KEEP = 16'h0003;
  localparam logic [15:0] QS_SLOW_KEEP = 16'h0004;
  localparam logic [15:0] FR_FAST      = 16'h0001;
  localparam logic [15:0] QSO_MAX      = 16'h0004;
  localparam logic [15:0] FRO_MAX      = 16'h0002;

  // state and control word bit positions
  localparam int SW_VOLT = 4;
  localparam int SW_WARN = 7;
  localparam int SW_REM  = 9;
  localparam int SW_TGT  = 10;
  localparam int SW_M12  = 12;
  localparam int SW_M13  = 13;
  localparam int CW_FRST = 7;

  // state word patterns, bits 6:5 and 3:0, bit 4 left clear
  localparam logic [6:0] PAT_NRDY = 7'h00;
  localparam logic [6:0] PAT_SOD  = 7'h40;
  localparam logic [6:0] PAT_RDY  = 7'h21;
  localparam logic [6:0] PAT_SWON = 7'h23;
  localparam logic [6:0] PAT_OPEN = 7'h27;
  localparam logic [6:0] PAT_QSTP = 7'h07;
  localparam logic [6:0] PAT_FRCT = 7'h0f;
  localparam logic [6:0] PAT_FLT  = 7'h08;

  // operating modes
  localparam logic [7:0] MODE_PP = 8'h01;
  localparam logic [7:0] MODE_PV = 8'h03;
  localparam logic [7:0] MODE_HM = 8'h06;
  localparam logic [7:0] MODE_IP = 8'h07;

  // control word masks and values
  localparam logic [15:0] CWM_SHUT = 16'h0087;
  localparam logic [15:0] CWV_SHUT = 16'h0006;
  localparam logic [15:0] CWM_ON   = 16'h008f;
  localparam logic [15:0] CWV_ON   = 16'h0007;
  localparam logic [15:0] CWV_EN   = 16'h000f;
  localparam logic [15:0] CWM_DV   = 16'h0082;
  localparam logic [15:0] CWV_DV   = 16'h0000;
  localparam logic [15:0] CWM_QS   = 16'h0086;
  localparam logic [15:0] CWV_QS   = 16'h0002;

  // millisecond timebase
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_NRDY = 3'h0, ST_SOD = 3'h1, ST_RDY = 3'h3, ST_SWON = 3'h2,
    ST_OPEN = 3'h6, ST_QSTP = 3'h7, ST_FRCT = 3'h5, ST_FLT = 3'h4
  } dss_state_t;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_SHUT, CMD_ON, CMD_EN, CMD_DV, CMD_QS
  } dss_cmd_t;

  // control word to command; disable op shares the switch-on code
  function automatic dss_cmd_t cw_cmd(input logic [15:0] cw);
    if ((cw & CWM_DV) == CWV_DV) return CMD_DV;
    if ((cw & CWM_QS) == CWV_QS) return CMD_QS;
    if ((cw & CWM_SHUT) == CWV_SHUT) return CMD_SHUT;
    if ((cw & CWM_ON) == CWV_ON) return CMD_ON;
    if ((cw & CWM_ON) == CWV_EN) return CMD_EN;
    return CMD_NONE;
  endfunction

endpackage

/* File: pkg/dss_ramp_if.sv */
// interface: deceleration ramp request and completion
interface dss_ramp_if;
  logic        start;
  logic        abort;
  logic [31:0] time_ms;
  logic        busy;
  logic        done;
  modport ctl (output start, output abort, output time_ms,
               input busy, input done);
  modport tmr (input start, input abort, input time_ms,
               output busy, output done);
endinterface

/* File: verilog/dss_ramp.sv */
// module: millisecond ramp timer for stop reactions
module dss_ramp #(
  parameter int unsigned CYC_PER_MS = dss_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic reset,
  dss_ramp_if.tmr  rif
);

  localparam int unsigned DW = $clog2(CYC_PER_MS + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(CYC_PER_MS - 1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic [31:0]   ms;
    logic          busy;
    logic          done;
  } dss_ramp_st_t;

  dss_ramp_st_t q;
  dss_ramp_st_t d;

  // restart wins over abort; zero time ends after one cycle
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (rif.start) begin
      d.busy = 1'b1;
      d.ms   = rif.time_ms;
      d.div  = '0;
    end else if (rif.abort) begin
      d.busy = 1'b0;
    end else if (q.busy) begin
      if (q.ms == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else if (q.div == DIV_LAST) begin
        d.div = '0;
        d.ms  = q.ms - 32'h0000_0001;
      end else begin
        d.div = q.div + DW'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rif.busy = q.busy;
  assign rif.done = q.done;

endmodule

/* File: verilog/dss_top.sv */
// module: drive state machine, state word and stop reaction objects
module dss_top #(
  parameter int unsigned CYC_PER_MS = dss_pkg::CYC_PER_MS
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        od_req,
  input  wire logic        od_we,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_sub,
  input  wire logic [31:0] od_wdata,
  output logic             od_ack_q,
  output logic             od_err_q,
  output logic [31:0]      od_rdata_q,
  input  wire logic [7:0]  op_mode,
  input  wire logic        fault_in,
  input  wire logic        warning_in,
  input  wire logic        voltage_ok,
  input  wire logic        target_reached,
  input  wire logic        sp_ack,
  input  wire logic        home_attained,
  input  wire logic        home_err,
  input  wire logic        follow_err,
  input  wire logic        ip_active,
  input  wire logic        zero_speed,
  output logic [15:0]      state_word_q,
  output logic             power_en_q,
  output logic             decel_active_q,
  output logic             decel_fast_q,
  output logic [31:0]      dout_force_q,
  output logic [31:0]      dout_en_q
);

  // ******************************************************************
  // state record
  // ******************************************************************

  typedef struct packed {
    dss_pkg::dss_state_t st;
    logic [15:0]         cw;
    logic [15:0]         qso;
    logic [15:0]         fro;
    logic [31:0]         slow;
    logic [31:0]         fast;
    logic [31:0]         dfor;
    logic [31:0]         den;
    logic [31:0]         rdata;
    logic                ack;
    logic                err;
    logic                frst;
    logic                rstart;
    logic                rabort;
    logic [31:0]         rtime;
    logic                rdone;
    logic                keep;
    logic                pwr;
    logic                dact;
    logic                dfast;
    logic [15:0]         sw;
  } dss_top_st_t;

  dss_top_st_t q;
  dss_top_st_t d;

  dss_ramp_if rif();

  dss_pkg::dss_cmd_t cmd;
  logic [31:0]       rd;
  logic              bad;
  logic              sub_ok;
  logic              wr;
  logic              go_react;
  logic              react_qs;
  logic              coast;
  logic              fast;
  logic              b12;
  logic              b13;

  // ******************************************************************
  // helpers
  // ******************************************************************

  // reaction code to {coast, fast}; quick stop codes 3/4 mirror 1/2
  function automatic logic [1:0] react(input logic [15:0] code,
                                       input logic        qs);
    logic c;
    logic f;
    c = (code == dss_pkg::OPT_COAST);
    if (qs) begin
      f = (code == dss_pkg::QS_FAST_DIS) |
          (code == dss_pkg::QS_FAST_KEEP);
    end else begin
      f = (code == dss_pkg::FR_FAST);
    end
    return {c, f};
  endfunction

  // state to bits 6:5 and 3:0 of the state word
  function automatic logic [6:0] pattern(input dss_pkg::dss_state_t s);
    logic [6:0] p;
    p = dss_pkg::PAT_NRDY;
    unique case (s)
      dss_pkg::ST_NRDY: p = dss_pkg::PAT_NRDY;
      dss_pkg::ST_SOD:  p = dss_pkg::PAT_SOD;
      dss_pkg::ST_RDY:  p = dss_pkg::PAT_RDY;
      dss_pkg::ST_SWON: p = dss_pkg::PAT_SWON;
      dss_pkg::ST_OPEN: p = dss_pkg::PAT_OPEN;
      dss_pkg::ST_QSTP: p = dss_pkg::PAT_QSTP;
      dss_pkg::ST_FRCT: p = dss_pkg::PAT_FRCT;
      dss_pkg::ST_FLT:  p = dss_pkg::PAT_FLT;
    endcase
    return p;
  endfunction

  // ******************************************************************
  // next state
  // ******************************************************************

  always_comb begin
    d        = q;
    d.ack    = 1'b0;
    d.err    = 1'b0;
    d.frst   = 1'b0;
    d.rstart = 1'b0;
    d.rabort = 1'b0;
    rd       = '0;
    bad      = 1'b0;
    sub_ok   = (od_sub == dss_pkg::SUB_0);
    wr       = od_we & sub_ok;
    go_react = 1'b0;
    react_qs = 1'b0;
    coast    = 1'b0;
    fast     = 1'b0;
    b12      = 1'b0;
    b13      = 1'b0;
    cmd      = dss_pkg::cw_cmd(q.cw);

    // object access; out-of-range option codes are refused whole
    if (od_req) begin
      unique case (od_index)
        dss_pkg::IDX_CTRL: begin
          rd = {16'h0000, q.cw};
          if (wr) begin
            d.cw   = od_wdata[15:0];
            d.frst = od_wdata[dss_pkg::CW_FRST] &
                     ~q.cw[dss_pkg::CW_FRST];
          end
        end
        dss_pkg::IDX_STAT: begin
          rd  = {16'h0000, q.sw};
          bad = od_we;
        end
        dss_pkg::IDX_SLOW: begin
          rd = q.slow;
          if (wr) d.slow = od_wdata;
        end
        dss_pkg::IDX_FAST: begin
          rd = q.fast;
          if (wr) d.fast = od_wdata;
        end
        dss_pkg::IDX_QSO: begin
          rd = {16'h0000, q.qso};
          if (wr) begin
            if (od_wdata[15:0] <= dss_pkg::QSO_MAX) begin
              d.qso = od_wdata[15:0];
            end else begin
              bad = 1'b1;
            end
          end
        end
        dss_pkg::IDX_FRO: begin
          rd = {16'h0000, q.fro};
          if (wr) begin
            if (od_wdata[15:0] <= dss_pkg::FRO_MAX) begin
              d.fro = od_wdata[15:0];
            end else begin
              bad = 1'b1;
            end
          end
        end
        dss_pkg::IDX_DOUT: begin
          sub_ok = 1'b1;
          case (od_sub)
            dss_pkg::SUB_0: begin
              rd  = dss_pkg::DOUT_SUBS;
              bad = od_we;
            end
            dss_pkg::SUB_1: begin
              rd = q.dfor;
              if (od_we) d.dfor = od_wdata;
            end
            dss_pkg::SUB_2: begin
              rd = q.den;
              if (od_we) d.den = od_wdata;
            end
            default: bad = 1'b1;
          endcase
        end
        default: bad = 1'b1;
      endcase
      d.ack   = 1'b1;
      d.err   = bad | ~sub_ok;
      d.rdata = (bad | ~sub_ok) ? '0 : rd;
    end

    // ramp completion; a stale done right after a restart is ignored
    if (rif.done & ~q.rstart) begin
      d.rdone = 1'b1;
    end

    // drive state transitions; a live fault outranks commands
    unique case (q.st)
      dss_pkg::ST_NRDY: begin
        d.st = dss_pkg::ST_SOD;
      end
      dss_pkg::ST_SOD: begin
        if (fault_in) begin
          d.st = dss_pkg::ST_FLT;
        end else if (cmd == dss_pkg::CMD_SHUT) begin
          d.st = dss_pkg::ST_RDY;
        end
      end
      dss_pkg::ST_RDY: begin
        if (fault_in) begin
          d.st = dss_pkg::ST_FLT;
        end else if (cmd == dss_pkg::CMD_DV) begin
          d.st = dss_pkg::ST_SOD;
        end else if (cmd == dss_pkg::CMD_ON) begin
          d.st = dss_pkg::ST_SWON;
        end
      end
      dss_pkg::ST_SWON: begin
        if (fault_in) begin
          d.st = dss_pkg::ST_FLT;
        end else if (cmd == dss_pkg::CMD_DV) begin
          d.st = dss_pkg::ST_SOD;
        end else if (cmd == dss_pkg::CMD_SHUT) begin
          d.st = dss_pkg::ST_RDY;
        end else if (cmd == dss_pkg::CMD_EN) begin
          d.st = dss_pkg::ST_OPEN;
        end
      end
      dss_pkg::ST_OPEN: begin
        if (fault_in) begin
          d.st     = dss_pkg::ST_FRCT;
          go_react = 1'b1;
        end else if (cmd == dss_pkg::CMD_DV) begin
          d.st = dss_pkg::ST_SOD;
        end else if (cmd == dss_pkg::CMD_SHUT) begin
          d.st = dss_pkg::ST_RDY;
        end else if (cmd == dss_pkg::CMD_ON) begin
          d.st = dss_pkg::ST_SWON;
        end else if (cmd == dss_pkg::CMD_QS) begin
          d.st     = dss_pkg::ST_QSTP;
          go_react = 1'b1;
          react_qs = 1'b1;
        end
      end
      dss_pkg::ST_QSTP: begin
        if (fault_in) begin
          d.st     = dss_pkg::ST_FRCT;
          go_react = 1'b1;
        end else if (cmd == dss_pkg::CMD_DV) begin
          d.st     = dss_pkg::ST_SOD;
          d.rabort = 1'b1;
        end else if (q.rdone) begin
          if (!q.keep) begin
            d.st = dss_pkg::ST_SOD;
          end else if (cmd == dss_pkg::CMD_EN) begin
            d.st = dss_pkg::ST_OPEN;
          end
        end
      end
      dss_pkg::ST_FRCT: begin
        if (q.rdone) begin
          d.st = dss_pkg::ST_FLT;
        end
      end
      dss_pkg::ST_FLT: begin
        if (q.frst & ~fault_in) begin
          d.st = dss_pkg::ST_SOD;
        end
      end
    endcase

    // start a reaction: coast ends at once, else ramp on chosen time
    if (go_react) begin
      {coast, fast} = react(react_qs ? q.qso : q.fro, react_qs);
      d.rdone  = coast;
      d.rstart = ~coast;
      d.rabort = coast;
      d.dfast  = fast;
      d.rtime  = fast ? q.fast : q.slow;
      d.keep   = react_qs &
                 ((q.qso == dss_pkg::QS_FAST_KEEP) |
                  (q.qso == dss_pkg::QS_SLOW_KEEP));
    end

    // power stage stays on through the ramp, or after it when kept
    d.pwr  = (d.st == dss_pkg::ST_OPEN) |
             (((d.st == dss_pkg::ST_QSTP) | (d.st == dss_pkg::ST_FRCT)) &
              (~d.rdone | (d.keep & (d.st == dss_pkg::ST_QSTP))));
    d.dact = ((d.st == dss_pkg::ST_QSTP) | (d.st == dss_pkg::ST_FRCT)) &
             ~d.rdone;

    // mode dependent bits; unknown modes read zero
    case (op_mode)
      dss_pkg::MODE_PP: begin
        b12 = sp_ack;
        b13 = follow_err;
      end
      dss_pkg::MODE_HM: begin
        b12 = home_attained;
        b13 = home_err;
      end
      dss_pkg::MODE_IP: b12 = ip_active;
      dss_pkg::MODE_PV: b12 = zero_speed;
      default: begin
        b12 = 1'b0;
        b13 = 1'b0;
      end
    endcase

    // state word follows the next state so it lines up with it
    d.sw                   = '0;
    d.sw[6:0]              = pattern(d.st);
    d.sw[dss_pkg::SW_VOLT] = voltage_ok;
    d.sw[dss_pkg::SW_WARN] = warning_in;
    d.sw[dss_pkg::SW_REM]  = 1'b1;
    d.sw[dss_pkg::SW_TGT]  = target_reached;
    d.sw[dss_pkg::SW_M12]  = b12;
    d.sw[dss_pkg::SW_M13]  = b13;
  end

  // ******************************************************************
  // registers
  // ******************************************************************

  // all objects reset to zero, state to not ready
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ******************************************************************
  // ramp timer
  // ******************************************************************

  // requests come from flops so the timer sees a clean pulse
  assign rif.start   = q.rstart;
  assign rif.abort   = q.rabort;
  assign rif.time_ms = q.rtime;

  dss_ramp #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ramp (
    .mclk  (mclk),
    .reset (reset),
    .rif   (rif)
  );

  // ******************************************************************
  // outputs
  // ******************************************************************

  assign od_ack_q       = q.ack;
  assign od_err_q       = q.err;
  assign od_rdata_q     = q.rdata;
  assign state_word_q   = q.sw;
  assign power_en_q     = q.pwr;
  assign decel_active_q = q.dact;
  assign decel_fast_q   = q.dfast;
  assign dout_force_q   = q.dfor;
  assign dout_en_q      = q.den;

endmodule

/* File: test/dss_monitor.sv */
// checker: object bus answers and state word properties
module dss_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        od_req,
  input wire logic        od_ack_q,
  input wire logic        od_err_q,
  input wire logic [15:0] state_word_q,
  input wire logic        power_en_q,
  input wire logic        decel_active_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [6:0] lo;
  logic [1:0] up_q;
  // voltage bit masked off, it follows an input
  assign lo = state_word_q[6:0] & 7'h6f;
  // word settles one edge after reset, checks wait for two
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) up_q <= 2'h0;
    else up_q <= {up_q[0], 1'b1};
  end
  ack_follows_a: assert property (od_req |=> od_ack_q)
    else $error("request without answer");
  ack_cause_a: assert property (od_ack_q |-> $past(od_req))
    else $error("answer without request");
  err_ack_a: assert property (od_err_q |-> od_ack_q)
    else $error("refusal outside answer");
  unused_bits_a: assert property (up_q[1] |->
    state_word_q[15:14] == 2'h0 && state_word_q[9])
    else $error("fixed state bits wrong");
  legal_code_a: assert property (up_q[1] |-> lo inside {7'h40,
    7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08})
    else $error("illegal state code");
  open_power_a: assert property (lo == 7'h27 |-> power_en_q)
    else $error("enabled without power");
  decel_state_a: assert property (decel_active_q |->
    lo inside {7'h07, 7'h0f})
    else $error("ramp outside stop states");
  fault_quiet_a: assert property (lo == 7'h08 |->
    !power_en_q && !decel_active_q)
    else $error("settled fault still driving");
  idle_off_a: assert property (lo inside {7'h40, 7'h21, 7'h23}
    |-> !power_en_q)
    else $error("power on while idle");
  ramp_end_a: assert property ($fell(decel_active_q) |=>
    lo inside {7'h40, 7'h07, 7'h08})
    else $error("ramp ended in wrong state");
  cover property (lo == 7'h07 && decel_active_q);
  cover property (lo == 7'h0f);
  cover property (od_ack_q && od_err_q);
endmodule

/* File: test/dss_master.sv */
// partner: fieldbus master issuing object accesses
module dss_master (
  input  wire logic        mclk,
  input  wire logic        od_ack_q,
  input  wire logic        od_err_q,
  input  wire logic [31:0] od_rdata_q,
  output logic             od_req,
  output logic             od_we,
  output logic [15:0]      od_index,
  output logic [7:0]       od_sub,
  output logic [31:0]      od_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    od_req = 1'b0;
    od_we = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 32'h0000_0000;
  end
  // one-cycle request; answer taken one cycle later
  task automatic acc(input logic we, input logic [15:0] ix,
    input logic [7:0] sb, input logic [31:0] wd,
    output logic [31:0] rd, output logic er, output logic ak);
    @(posedge mclk);
    od_req <= 1'b1;
    od_we <= we;
    od_index <= ix;
    od_sub <= sb;
    od_wdata <= wd;
    @(posedge mclk);
    od_req <= 1'b0;
    // released lines show no stale value
    od_index <= ~ix;
    od_sub <= ~sb;
    od_wdata <= ~wd;
    @(negedge mclk);
    rd = od_rdata_q;
    er = od_err_q;
    ak = od_ack_q;
  endtask
  // enabling sequence of control words
  task automatic enable();
    logic [31:0] r;
    logic e, a;
    acc(1'b1, dss_pkg::IDX_CTRL, 8'h00, 32'h6, r, e, a);
    acc(1'b1, dss_pkg::IDX_CTRL, 8'h00, 32'h7, r, e, a);
    acc(1'b1, dss_pkg::IDX_CTRL, 8'h00, 32'hf, r, e, a);
  endtask
  // fault reset needs bit 7 low first, then raised
  task automatic freset();
    logic [31:0] r;
    logic e, a;
    acc(1'b1, dss_pkg::IDX_CTRL, 8'h00, 32'h0, r, e, a);
    acc(1'b1, dss_pkg::IDX_CTRL, 8'h00, 32'h80, r, e, a);
  endtask
endmodule

/* File: test/tb.sv */
// testbench: drive states, stop reactions and object access
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned CPM = 4;
  logic mclk = 1'b0, reset = 1'b1, fault_in = 1'b0, voltage_ok = 1'b1;
  logic [7:0] op_mode = 8'h01;
  logic warning_in = 1'b0, target_reached = 1'b0, sp_ack = 1'b0;
  logic home_attained = 1'b0, home_err = 1'b0, follow_err = 1'b0;
  logic ip_active = 1'b0, zero_speed = 1'b0;
  logic od_req, od_we, od_ack_q, od_err_q, power_en_q, er, ak;
  logic decel_active_q, decel_fast_q;
  logic [15:0] od_index, state_word_q;
  logic [7:0] od_sub;
  logic [31:0] od_wdata, od_rdata_q, dout_force_q, dout_en_q, rd, v;
  int num_errors = 0, total_checks = 0;
  int unsigned seed = 65;
  int unsigned mdl[int];
  logic [23:0] keys[6] = '{24'h605000, 24'h605100, 24'h605a00,
    24'h605e00, 24'h60fe01, 24'h60fe02};
  logic bw[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [15:0] bi[7] = '{16'h6041, 16'h60fe, 16'h605a, 16'h605e,
    16'h6042, 16'h6050, 16'h60fe};
  logic [7:0] bs[7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h3};
  logic [31:0] bd[7] = '{32'h1, 32'h1, 32'h5, 32'h3, 32'h0, 32'h0, 32'h0};
  logic [7:0] modes[5] = '{8'h01, 8'h06, 8'h07, 8'h03, 8'h08};
  logic [6:0] seqp[5] = '{7'h21, 7'h23, 7'h27, 7'h23, 7'h27};
  logic [31:0] seqw[5] = '{32'h6, 32'h7, 32'hf, 32'h7, 32'hf};
  dss_top #(.CYC_PER_MS(CPM)) dss_top_i (.mclk(mclk), .reset(reset),
    .od_req(od_req), .od_we(od_we), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_ack_q(od_ack_q),
    .od_err_q(od_err_q), .od_rdata_q(od_rdata_q), .op_mode(op_mode),
    .fault_in(fault_in), .warning_in(warning_in),
    .voltage_ok(voltage_ok), .target_reached(target_reached),
    .sp_ack(sp_ack), .home_attained(home_attained),
    .home_err(home_err), .follow_err(follow_err),
    .ip_active(ip_active), .zero_speed(zero_speed),
    .state_word_q(state_word_q), .power_en_q(power_en_q),
    .decel_active_q(decel_active_q), .decel_fast_q(decel_fast_q),
    .dout_force_q(dout_force_q), .dout_en_q(dout_en_q));
  dss_master dss_master_i (.mclk(mclk), .od_ack_q(od_ack_q),
    .od_err_q(od_err_q), .od_rdata_q(od_rdata_q), .od_req(od_req),
    .od_we(od_we), .od_index(od_index), .od_sub(od_sub),
    .od_wdata(od_wdata));
  // clock, 8 ns period
  initial begin
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] lo();
    return state_word_q[6:0] & 7'h6f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rw(input logic w, input logic [15:0] i,
    input logic [7:0] s, input logic [31:0] d);
    dss_master_i.acc(w, i, s, d, rd, er, ak);
    chk("ack", ak, 1'b1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // length of a running ramp, in cycles
  task automatic ramp(input int t);
    int n;
    n = 0;
    while (decel_active_q === 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("ramp_len", n >= t * CPM - 1 && n <= t * CPM + 3, 1'b1);
  endtask
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    cyc(3);
    chk("sw_reset", state_word_q, 16'h0250);
    for (int i = 0; i < 6; i++) begin
      rw(1'b0, keys[i][23:8], keys[i][7:0], 32'h0);
      chk("reset_val", rd, 32'h0);
    end
    rw(1'b0, 16'h60fe, 8'h00, 32'h0);
    chk("dout_count", rd, 32'h2);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      if (i == 2 || i == 3) continue;
      v = xs();
      mdl[keys[i]] = v;
      rw(1'b1, keys[i][23:8], keys[i][7:0], v);
      rw(1'b0, keys[i][23:8], keys[i][7:0], 32'h0);
      chk("rw32", rd, mdl[keys[i]]);
    end
    chk("force_out", dout_force_q, mdl[keys[4]]);
    chk("enable_out", dout_en_q, mdl[keys[5]]);
    for (int j = 0; j < 7; j++) begin
      rw(bw[j], bi[j], bs[j], bd[j]);
      chk("refused", er, 1'b1);
      chk("refused_rd", rd, 32'h0);
    end
    rw(1'b0, 16'h605a, 8'h00, 32'h0);
    chk("qs_kept", rd, 32'h0);
    rw(1'b1, 16'h6050, 8'h00, 32'h2);
    rw(1'b1, 16'h6051, 8'h00, 32'h1);
    $display("object access done");
    for (int k = 0; k < 5; k++) begin
      rw(1'b1, 16'h6040, 8'h00, seqw[k]);
      cyc(1);
      chk("enable_seq", lo(), seqp[k]);
    end
    chk("power_on", power_en_q, 1'b1);
    for (int c = 0; c < 5; c++) begin
      rw(1'b1, 16'h605a, 8'h00, c);
      rw(1'b1, 16'h6040, 8'h00, 32'h0);
      dss_master_i.enable();
      rw(1'b1, 16'h6040, 8'h00, 32'h2);
      cyc(1);
      chk("qs_state", lo(), 7'h07);
      chk("qs_power", power_en_q, c != 0);
      if (c != 0) begin
        chk("qs_fast", decel_fast_q, c == 1 || c == 3);
        ramp((c == 1 || c == 3) ? 1 : 2);
      end
      cyc(2);
      chk("qs_end", lo(), c < 3 ? 7'h40 : 7'h07);
      chk("qs_hold", power_en_q, c >= 3);
    end
    $display("quick stop codes done");
    for (int c = 0; c < 3; c++) begin
      rw(1'b1, 16'h605e, 8'h00, c);
      rw(1'b1, 16'h6040, 8'h00, 32'h0);
      dss_master_i.enable();
      @(posedge mclk);
      fault_in <= 1'b1;
      cyc(2);
      if (c != 0) begin
        chk("fr_state", lo(), 7'h0f);
        chk("fr_fast", decel_fast_q, c == 1);
        ramp(c == 1 ? 1 : 2);
      end
      cyc(3);
      chk("fault", lo(), 7'h08);
      rw(1'b1, 16'h6040, 8'h00, 32'h80);
      cyc(2);
      chk("fault_held", lo(), 7'h08);
      @(posedge mclk);
      fault_in <= 1'b0;
      dss_master_i.freset();
      cyc(2);
      chk("fault_reset", lo(), 7'h40);
    end
    $display("fault reactions done");
    for (int m = 0; m < 5; m++) begin
      for (int r = 0; r < 4; r++) begin
        v = xs();
        @(posedge mclk);
        op_mode <= modes[m];
        {voltage_ok, sp_ack, home_attained, ip_active, zero_speed,
          follow_err, home_err, warning_in, target_reached} <= v[8:0];
        cyc(3);
        case (modes[m])
          dss_pkg::MODE_PP: chk("bit12", state_word_q[12], v[7]);
          dss_pkg::MODE_HM: chk("bit12", state_word_q[12], v[6]);
          dss_pkg::MODE_IP: chk("bit12", state_word_q[12], v[5]);
          dss_pkg::MODE_PV: chk("bit12", state_word_q[12], v[4]);
          default: chk("bit12", state_word_q[12], 1'b0);
        endcase
        chk("bit13", state_word_q[13], modes[m] == 8'h01 ? v[3] :
          modes[m] == 8'h06 ? v[2] : 1'b0);
        chk("warn", state_word_q[7], v[1]);
        chk("target", state_word_q[10], v[0]);
        chk("volt", state_word_q[4], v[8]);
      end
    end
    $display("mode bits done");
    complete_run();
  end
endmodule
bind dss_top dss_monitor dss_monitor_i (.mclk(mclk), .reset(reset),
  .od_req(od_req), .od_ack_q(od_ack_q), .od_err_q(od_err_q),
  .state_word_q(state_word_q), .power_en_q(power_en_q),
  .decel_active_q(decel_active_q));
